// >>> hdl/tlac_alert.sv
`timescale 1ns/1ns
`default_nettype none
`include "tlac_consts.svh"
// Summary of operation
// - comparator: alarm after N consecutive at/above upper
// - comparator: release after N consecutive below lower
// - interrupt: alarm after N consecutive at/above upper
// - interrupt: any register read clears alarm
// - interrupt: entering shutdown clears alarm
// - interrupt: then alarm on N below lower
// - interrupt: thresholds alternate forever
// - combined mode: set upper, release lower, counted
// - reset limits: upper 80 C, lower 75 C
// - limits use 13-bit left-justified temperature format
// - compare all 13 bits at every resolution
// - resolution bits pick 9..12 bits, 30..240 ms
// - power up at 12-bit resolution
// - delay bits set start spacing 0.25/0.5/1/8 s
// - power up with delay bits cleared
// - period start-to-start, both scale with resolution
// - fault queue needs 1, 2, 4 or 6
// - polarity bit: 0 active low, 1 active high
module tlac_alert #(
    parameter int unsigned CONV12_CYC   = 32'(`TLAC_CONV12_MS * `TLAC_CLK_HZ / 64'd1000),
    parameter int unsigned PERIOD12_CYC = 32'(`TLAC_PERIOD12_MS * `TLAC_CLK_HZ / 64'd1000)
) (
    input  wire logic        clk_sys_i,     // system clock, 20 MHz
    input  wire logic        reset_i,       // reset, active high; asynchronous on the sck-side handover flops
    input  wire logic        spi_sck_i,     // serial clock from host
    input  wire logic        spi_cs_n_i,    // frame select, active low
    input  wire logic        spi_mosi_i,    // serial data in
    output logic             spi_miso_o,    // serial data out
    output logic             spi_miso_oe_o, // high while miso is driven
    input  wire logic [12:0] temp_sample_i, // converter result, sys domain
    output logic             conv_active_o, // converter running
    output logic             alert_o        // alarm pin level
);
    import tlac_pkg::*;

    if (CONV12_CYC < 8 || PERIOD12_CYC < CONV12_CYC) begin : g_bad_param
        $error("tlac_alert: timing counts too small or inconsistent");
    end

    // fault queue depth for a setting
    function automatic logic [2:0] fq_need(input logic [1:0] fq);
        unique case (fq)
            2'h0: fq_need = 3'h1;
            2'h1: fq_need = 3'h2;
            2'h2: fq_need = 3'h4;
            2'h3: fq_need = 3'h6;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic [5:0]  bit_cnt_r, bit_cnt_nxt; // sck edges in frame
    logic [15:0] shin_r, shin_nxt;       // input shifter
    logic [15:0] cmd_r, cmd_nxt;         // command word of frame
    logic [15:0] xcmd_r, xcmd_nxt;       // command handed to sys
    logic [15:0] xdat_r, xdat_nxt;       // data handed to sys
    logic        xtgl_r, xtgl_nxt;       // frame-done toggle
    logic        miso_r, miso_nxt;       // output bit
    logic        oe_r, oe_nxt;           // output phase
    logic [15:0] rd_word;                // word chosen by command
    logic        cs_n_s, xtgl_s;         // synchronised levels
    logic        xtgl_d_r;               // last seen toggle
    logic        xfer_ev, wr_ev, rd_ev;  // frame events, sys domain
    logic        shdn_set, shdn_enter;   // shutdown command / entry
    logic        shutdown_r, shutdown_nxt; // shutdown_control state
    logic [12:0] upper_r, upper_nxt;     // upper_limit
    logic [12:0] lower_r, lower_nxt;     // lower_limit
    logic [12:0] temp_r, temp_nxt;       // last result
    logic [1:0]  dly_r, dly_nxt;         // conversion_delay_bits
    logic [1:0]  res_r, res_nxt;         // resolution_bits
    logic [1:0]  fq_r, fq_nxt;           // fault_queue_bits
    logic        pol_r, pol_nxt;         // alarm_polarity
    tlac_mode_t  tm_r, tm_nxt;           // thermostat_mode_bits
    logic [15:0] snap_r [4];             // frozen read words
    logic [15:0] live_w [4];             // current read words
    tlac_conv_t  cv_r, cv_nxt;           // scheduler state
    logic [31:0] cyc_r, cyc_nxt;         // cycles since start
    logic [31:0] conv_cyc, period_cyc;   // scaled lengths
    logic [2:0]  dly_shift;              // period multiplier log2
    logic [1:0]  res_sh;                 // 3 - resolution
    logic        done;                   // conversion ends now
    logic [12:0] new_temp;               // masked sample
    logic        hi_hit, lo_hit, cond;   // threshold tests
    logic        is_int, want_low;       // mode decode
    logic        alarm_r, alarm_nxt;     // internal alarm level
    logic        arm_low_r, arm_nxt;     // interrupt arm side
    logic [2:0]  fcnt_r, fcnt_nxt;       // consecutive faults
    logic        alert_r, alert_nxt;     // pin register

    ////////////////////////////////////////////////////////////////////
    // sck domain: input shift, cleared by frame deselect
    always_comb begin
        shin_nxt    = {shin_r[14:0], spi_mosi_i};
        bit_cnt_nxt = (bit_cnt_r == `TLAC_FRAME_BITS) ? bit_cnt_r : bit_cnt_r + 6'h01;
        cmd_nxt     = (bit_cnt_r == `TLAC_CMD_BITS - 6'h01) ? shin_nxt : cmd_r;
    end

    always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            bit_cnt_r <= 6'h00;
            shin_r    <= 16'h0000;
            cmd_r     <= 16'h0000;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            shin_r    <= shin_nxt;
            cmd_r     <= cmd_nxt;
        end
    end

    // frame-end capture, handed over by toggle
    always_comb begin
        xcmd_nxt = xcmd_r;
        xdat_nxt = xdat_r;
        xtgl_nxt = xtgl_r;
        if (bit_cnt_r == `TLAC_FRAME_BITS - 6'h01) begin
            xcmd_nxt = cmd_r;
            xdat_nxt = shin_nxt;
            xtgl_nxt = ~xtgl_r;
        end
    end

    always_ff @(posedge spi_sck_i or posedge reset_i) begin
        if (reset_i) begin
            xcmd_r <= 16'h0000;
            xdat_r <= 16'h0000;
            xtgl_r <= 1'b0;
        end else begin
            xcmd_r <= xcmd_nxt;
            xdat_r <= xdat_nxt;
            xtgl_r <= xtgl_nxt;
        end
    end

    // output: snapshot is frozen while the frame is selected
    always_comb begin
        rd_word  = snap_r[cmd_r[`TLAC_CMD_ADDR_LSB +: 2]];
        oe_nxt   = (bit_cnt_r[5:4] == 2'h1) && !cmd_r[`TLAC_CMD_WR_BIT];
        miso_nxt = rd_word[~bit_cnt_r[3:0]];
    end

    // shift out on falling edges, msb first
    always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            miso_r <= 1'b0;
            oe_r   <= 1'b0;
        end else begin
            miso_r <= miso_nxt;
            oe_r   <= oe_nxt;
        end
    end

    assign spi_miso_o    = miso_r;
    assign spi_miso_oe_o = oe_r & ~spi_cs_n_i;

    ////////////////////////////////////////////////////////////////////
    // crossing into the system domain
    tlac_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (clk_sys_i),
        .reset_i (reset_i),
        .d_i     ({spi_cs_n_i, xtgl_r}),
        .q_o     ({cs_n_s, xtgl_s})
    );

    // frame decode; xcmd/xdat are stable long before the toggle lands
    always_comb begin
        xfer_ev    = xtgl_s ^ xtgl_d_r;
        wr_ev      = xfer_ev && xcmd_r[`TLAC_CMD_WR_BIT];
        rd_ev      = xfer_ev && !xcmd_r[`TLAC_CMD_WR_BIT];
        shdn_set   = wr_ev && (xcmd_r[7:0] == `TLAC_SHDN_CODE);
        shdn_enter = shdn_set && !shutdown_r;
        // any other frame leaves shutdown
        shutdown_nxt = xfer_ev ? shdn_set : shutdown_r;
    end

    ////////////////////////////////////////////////////////////////////
    // register writes
    always_comb begin
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        dly_nxt   = dly_r;
        res_nxt   = res_r;
        fq_nxt    = fq_r;
        pol_nxt   = pol_r;
        tm_nxt    = tm_r;
        if (wr_ev && !shdn_set) begin
            unique case (xcmd_r[`TLAC_CMD_ADDR_LSB +: 2])
                `TLAC_ADDR_HIGH: upper_nxt = xdat_r[15:3];
                `TLAC_ADDR_LOW:  lower_nxt = xdat_r[15:3];
                `TLAC_ADDR_CFG: begin
                    dly_nxt = xdat_r[`TLAC_CFG_DLY_LSB +: 2];
                    res_nxt = xdat_r[`TLAC_CFG_RES_LSB +: 2];
                    fq_nxt  = xdat_r[`TLAC_CFG_FQ_LSB +: 2];
                    pol_nxt = xdat_r[`TLAC_CFG_POL_BIT];
                    tm_nxt  = tlac_mode_t'(xdat_r[`TLAC_CFG_TM_LSB +: 2]);
                end
                `TLAC_ADDR_TEMP: begin
                    // result is read only
                end
            endcase
        end
    end

    // live read words, the limits laid out like the result word
    always_comb begin
        live_w[0] = {temp_r, `TLAC_TEMP_TAIL};
        live_w[1] = {4'h0, dly_r, res_r, fq_r, pol_r, tm_r, `TLAC_CFG_TAIL};
        live_w[2] = {lower_r, `TLAC_LOW_TAIL};
        live_w[3] = {upper_r, `TLAC_HIGH_TAIL};
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            upper_r    <= `TLAC_UPPER_RST;
            lower_r    <= `TLAC_LOWER_RST;
            dly_r      <= `TLAC_DLY_RST;
            res_r      <= `TLAC_RES_RST;
            fq_r       <= `TLAC_FQ_RST;
            pol_r      <= `TLAC_POL_RST;
            tm_r       <= TLAC_TM_CMP;
            shutdown_r <= 1'b0;
            xtgl_d_r   <= 1'b0;
        end else begin
            upper_r    <= upper_nxt;
            lower_r    <= lower_nxt;
            dly_r      <= dly_nxt;
            res_r      <= res_nxt;
            fq_r       <= fq_nxt;
            pol_r      <= pol_nxt;
            tm_r       <= tm_nxt;
            shutdown_r <= shutdown_nxt;
            xtgl_d_r   <= xtgl_s;
        end
    end

    // snapshot follows the registers only while deselected
    for (genvar a = 0; a < 4; a++) begin : g_snap
        always_ff @(posedge clk_sys_i) begin
            if (reset_i) begin
                snap_r[a] <= 16'h0000;
            end else if (cs_n_s) begin
                snap_r[a] <= live_w[a];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion scheduler
    always_comb begin
        res_sh = 2'h3 - res_r;
        unique case (dly_r)
            2'h0: dly_shift = 3'h0;
            2'h1: dly_shift = 3'h1;
            2'h2: dly_shift = 3'h2;
            2'h3: dly_shift = 3'h5;
        endcase
        conv_cyc   = CONV12_CYC >> res_sh;
        period_cyc = (PERIOD12_CYC << dly_shift) >> res_sh;
        done       = (cv_r == TLAC_CV_BUSY) && (cyc_r >= conv_cyc - 32'h1);
        cv_nxt     = cv_r;
        cyc_nxt    = cyc_r + 32'h1;
        unique case (cv_r)
            TLAC_CV_IDLE: begin
                cyc_nxt = 32'h0;
                if (!shutdown_r) begin
                    cv_nxt = TLAC_CV_BUSY;
                end
            end
            TLAC_CV_BUSY: begin
                if (done) begin
                    cv_nxt = TLAC_CV_WAIT;
                end
            end
            TLAC_CV_WAIT: begin
                // start-to-start spacing
                if (cyc_r >= period_cyc - 32'h1) begin
                    cyc_nxt = 32'h0;
                    cv_nxt  = shutdown_r ? TLAC_CV_IDLE : TLAC_CV_BUSY;
                end
            end
            default: begin
                cv_nxt  = TLAC_CV_IDLE;
                cyc_nxt = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cv_r  <= TLAC_CV_IDLE;
            cyc_r <= 32'h0;
        end else begin
            cv_r  <= cv_nxt;
            cyc_r <= cyc_nxt;
        end
    end

    assign conv_active_o = (cv_r == TLAC_CV_BUSY);

    ////////////////////////////////////////////////////////////////////
    // result capture and alarm filter
    always_comb begin
        new_temp  = temp_sample_i & (13'h1fff << res_sh); // unused lsbs zero
        temp_nxt  = done ? new_temp : temp_r;
        hi_hit    = $signed(new_temp) >= $signed(upper_r);
        lo_hit    = $signed(new_temp) < $signed(lower_r);
        is_int    = (tm_r == TLAC_TM_INT);
        want_low  = is_int ? arm_low_r : alarm_r;
        cond      = want_low ? lo_hit : hi_hit;
        alarm_nxt = alarm_r;
        arm_nxt   = arm_low_r;
        fcnt_nxt  = fcnt_r;
        // clears first so a same-cycle set wins
        if (is_int && (rd_ev || shdn_enter)) begin
            alarm_nxt = 1'b0;
        end
        if (done) begin
            if (is_int && alarm_r) begin
                fcnt_nxt = 3'h0; // wait for the read
            end else if (cond) begin
                if (fcnt_r + 3'h1 >= fq_need(fq_r)) begin
                    fcnt_nxt = 3'h0;
                    if (is_int) begin
                        alarm_nxt = 1'b1;
                        arm_nxt   = ~arm_low_r;
                    end else begin
                        alarm_nxt = ~alarm_r;
                    end
                end else begin
                    fcnt_nxt = fcnt_r + 3'h1;
                end
            end else begin
                fcnt_nxt = 3'h0;
            end
        end
        alert_nxt = pol_r ? alarm_r : ~alarm_r;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            temp_r    <= `TLAC_TEMP_RST;
            alarm_r   <= 1'b0;
            arm_low_r <= 1'b0;
            fcnt_r    <= 3'h0;
            alert_r   <= 1'b1;
        end else begin
            temp_r    <= temp_nxt;
            alarm_r   <= alarm_nxt;
            arm_low_r <= arm_nxt;
            fcnt_r    <= fcnt_nxt;
            alert_r   <= alert_nxt;
        end
    end

    assign alert_o = alert_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    sequence s_trip;
        done && cond && (fcnt_r + 3'h1 >= fq_need(fq_r)) && !(is_int && alarm_r);
    endsequence
    sequence s_cmp_idle;
        !is_int && !alarm_r;
    endsequence

    alert_pol_a: assert property (alert_o == ($past(pol_r) ? $past(alarm_r) : !$past(alarm_r)))
        else $error("alert pin level disagrees with polarity");
    cmp_set_a: assert property (s_cmp_idle ##0 s_trip |=> alarm_r ##1 (alert_o == pol_r))
        else $error("comparator alarm not raised after fault run");
    cmp_hold_a: assert property (!is_int && alarm_r && !(done && lo_hit) |=> alarm_r)
        else $error("comparator alarm dropped early");
    int_clear_a: assert property (is_int && rd_ev && !(done && cond && !alarm_r
                                  && (fcnt_r + 3'h1 >= fq_need(fq_r))) |=> !alarm_r)
        else $error("read did not clear interrupt alarm");
    shut_clear_a: assert property (is_int && shdn_enter && !done |=> !alarm_r)
        else $error("shutdown did not clear interrupt alarm");
    arm_flip_a: assert property (is_int && $rose(alarm_r) |-> arm_low_r != $past(arm_low_r))
        else $error("interrupt arm side did not alternate");
    fault_clr_a: assert property (done && !cond |=> fcnt_r == 3'h0)
        else $error("fault run not cleared");
    // a clear taken in the same cycle is the only legal move of the alarm
    run_short_a: assert property (done && cond && (fcnt_r + 3'h1 < fq_need(fq_r))
                                  |=> $stable(alarm_r) || $past(rd_ev || shdn_enter))
        else $error("alarm moved before fault run complete");
    reset_val_a: assert property ($fell(reset_i) |-> upper_r == `TLAC_UPPER_RST && lower_r == `TLAC_LOWER_RST
                                  && res_r == 2'h3 && dly_r == 2'h0 && fq_r == 2'h0)
        else $error("power-up values wrong");
    conv_len_a: assert property ($rose(conv_active_o) |-> cyc_r == 32'h0)
        else $error("conversion did not start at zero count");
    // a resolution drop mid-run ends that conversion early, so only steady runs are timed
    conv_end_a: assert property (done && $stable(res_r) |-> cyc_r == conv_cyc - 32'h1 ##1 !conv_active_o)
        else $error("conversion length wrong");
endmodule
`default_nettype wire

// >>> hdl/tlac_consts.svh
`ifndef TLAC_CONSTS_SVH
`define TLAC_CONSTS_SVH
// register addresses as carried in the command word
`define TLAC_ADDR_TEMP    2'h0
`define TLAC_ADDR_CFG     2'h1
`define TLAC_ADDR_LOW     2'h2
`define TLAC_ADDR_HIGH    2'h3
// command word layout
`define TLAC_CMD_WR_BIT   15
`define TLAC_CMD_ADDR_LSB 8
`define TLAC_SHDN_CODE    8'hff
// frame length in sck edges
`define TLAC_CMD_BITS     6'h10
`define TLAC_FRAME_BITS   6'h20
// configuration field positions
`define TLAC_CFG_DLY_LSB  10
`define TLAC_CFG_RES_LSB  8
`define TLAC_CFG_FQ_LSB   6
`define TLAC_CFG_POL_BIT  5
`define TLAC_CFG_TM_LSB   3
// fixed low bits of the read words
`define TLAC_TEMP_TAIL    3'h4
`define TLAC_CFG_TAIL     3'h2
`define TLAC_LOW_TAIL     3'h4
`define TLAC_HIGH_TAIL    3'h6
// reset values
`define TLAC_TEMP_RST     13'h0000
`define TLAC_UPPER_RST    13'h0500
`define TLAC_LOWER_RST    13'h04b0
`define TLAC_RES_RST      2'h3
`define TLAC_DLY_RST      2'h0
`define TLAC_FQ_RST       2'h0
`define TLAC_POL_RST      1'b0
// timing, in their own units
`define TLAC_CLK_HZ       64'd20000000
`define TLAC_CONV12_MS    64'd240
`define TLAC_PERIOD12_MS  64'd250
`endif

// >>> hdl/tlac_pkg.sv
package tlac_pkg;
    // thermostat mode codes
    typedef enum logic [1:0] {
        TLAC_TM_CMP  = 2'b00,
        TLAC_TM_INT  = 2'b01,
        TLAC_TM_COMB = 2'b10,
        TLAC_TM_RSVD = 2'b11
    } tlac_mode_t;
    // conversion scheduler states
    typedef enum logic [1:0] {
        TLAC_CV_IDLE = 2'b00,
        TLAC_CV_BUSY = 2'b01,
        TLAC_CV_WAIT = 2'b10
    } tlac_conv_t;
endpackage

// >>> hdl/tlac_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop level synchroniser, one pair per bit
module tlac_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,   // destination clock
    input  wire logic             reset_i, // synchronous, active high
    input  wire logic [WIDTH-1:0] d_i,     // foreign-domain levels
    output logic      [WIDTH-1:0] q_o      // synchronised levels
);
    if (WIDTH < 1) begin : g_bad_width
        $error("tlac_sync: WIDTH must be at least 1");
    end
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_r; // first stage, read only by the second
        logic sync_r; // second stage
        // two stages, nothing taps the first
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                meta_r <= 1'b0;
                sync_r <= 1'b0;
            end else begin
                meta_r <= d_i[i];
                sync_r <= meta_r;
            end
        end
        assign q_o[i] = sync_r;
    end
endmodule
`default_nettype wire

// >>> tb/tlac_alert_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "tlac_consts.svh"
////////////////////////////////////////////////////////////
// self-checking bench: scheduler timing, alarm modes, register access
module tlac_alert_tb_top;
    import tlac_pkg::*;
    localparam int         CONV12   = 48;               // shortened full-resolution conversion
    localparam int         PER12    = 50;               // shortened full-resolution period
    localparam int         NEED[4]  = '{1, 2, 4, 6};    // faults needed per queue code
    localparam int         DSH[4]   = '{0, 1, 2, 5};    // period shift per delay code
    localparam tlac_mode_t MODES[4] = '{TLAC_TM_CMP, TLAC_TM_COMB, TLAC_TM_RSVD, TLAC_TM_CMP};
    logic                  clk      = 1'b0;             // system clock
    logic                  rst;                         // synchronous reset, raised at time zero
    logic [12:0]           temp     = 13'h0000;         // converter sample
    logic                  sck, cs_n, mosi, miso, miso_oe, conv_act, alert;
    logic [15:0]           rd;                          // last word read
    logic [12:0]           v;                           // random limit
    logic [1:0]            r2;                          // random resolution
    int                    failures = 0;
    int                    compares = 0;
    int                    cyc      = 0;
    int                    n, hi, per;

    always #25 clk = ~clk;

    tlac_alert #(.CONV12_CYC(CONV12), .PERIOD12_CYC(PER12)) u_dut (
        .clk_sys_i(clk), .reset_i(rst), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .temp_sample_i(temp), .conv_active_o(conv_act),
        .alert_o(alert));
    tlac_host u_host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

    ////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic tally_and_finish();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // shared comparison, four-state exact
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
        cmp(32'(e), 32'(g));
    endtask
    task automatic chk_pin(input logic e, input logic g);
        cmp(32'(e), 32'(g));
    endtask
    task automatic chk_cnt(input int e, input int g);
        cmp(32'(e), 32'(g));
    endtask
    // expected configuration read word
    function automatic logic [15:0] cfg_word(logic [1:0] d, logic [1:0] r, logic [1:0] f, logic p, logic [1:0] m);
        return {4'h0, d, r, f, p, m, 3'b010};
    endfunction
    // expected result word: unused low bits zero at lower resolution
    function automatic logic [15:0] res_word(logic [12:0] t, logic [1:0] r);
        return {t & (13'h1fff << (2'd3 - r)), 3'b100};
    endfunction
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        u_host.frame({1'b1, 5'h00, a, 8'h00}, d, rd);
    endtask
    task automatic rdreg(input logic [1:0] a);
        u_host.frame({1'b0, 5'h00, a, 8'h00}, 16'h0000, rd);
    endtask
    task automatic set_temp(input logic [12:0] t);
        @(posedge clk);
        temp <= t;
    endtask
    // wait on the converter flag, bounded
    task automatic wait_act(input logic lvl, inout int k);
        while (conv_act !== lvl && k < 4000) begin
            @(negedge clk);
            k++;
        end
    endtask
    // end of the next conversion, then let the alarm settle
    task automatic conv_end();
        int k;
        k = 0;
        wait_act(1'b1, k);
        wait_act(1'b0, k);
        if (k >= 4000) begin
            failures++;
        end
        repeat (3) @(negedge clk);
    endtask
    // high time and start-to-start time of one conversion
    task automatic measure();
        int k;
        k = 0;
        wait_act(1'b0, k);
        wait_act(1'b1, k);
        k = 0;
        wait_act(1'b0, k);
        hi = k;
        wait_act(1'b1, k);
        per = k;
    endtask
    // conversions until the pin reaches a level, at most 8
    task automatic count_to(input logic lvl);
        n = 0;
        while (alert !== lvl && n < 8) begin
            conv_end();
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        // a real rising edge, so the link-side handover flops clear as well
        rst <= 1'b1;
        void'($urandom(72494));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rdreg(`TLAC_ADDR_HIGH);
        chk_word(16'h2806, rd);
        rdreg(`TLAC_ADDR_LOW);
        chk_word(16'h2584, rd);
        rdreg(`TLAC_ADDR_CFG);
        chk_word(16'h0302, rd);
        // conversion length and spacing for every resolution and delay code
        for (int r = 0; r < 4; r++) begin
            wr(`TLAC_ADDR_CFG, cfg_word(2'(3 - r), 2'(r), 2'h0, 1'b0, TLAC_TM_CMP));
            measure();
            measure();
            chk_cnt(CONV12 >> (3 - r), hi);
            chk_cnt((PER12 << DSH[3 - r]) >> (3 - r), per);
        end
        // counted set and release in comparator-like modes, both polarities
        wr(`TLAC_ADDR_HIGH, {13'h0501, 3'h0});
        for (int k = 0; k < 4; k++) begin
            wr(`TLAC_ADDR_CFG, cfg_word(2'h1, 2'h0, 2'(k), k[0], MODES[k]));
            set_temp(13'h0507);
            repeat (7) conv_end();
            chk_pin(~k[0], alert);
            set_temp(13'h0508);
            count_to(k[0]);
            chk_cnt(NEED[k], n);
            set_temp(13'h04b0);
            repeat (7) conv_end();
            chk_pin(k[0], alert);
            set_temp(13'h04af);
            count_to(~k[0]);
            chk_cnt(NEED[k], n);
        end
        // interrupt mode: alternate thresholds, cleared by reads and by shutdown
        wr(`TLAC_ADDR_CFG, cfg_word(2'h1, 2'h0, 2'h0, 1'b0, TLAC_TM_INT));
        set_temp(13'h0600);
        conv_end();
        chk_pin(1'b0, alert);
        set_temp(13'h04c0);
        repeat (3) conv_end();
        chk_pin(1'b0, alert);
        rdreg(`TLAC_ADDR_LOW);
        chk_pin(1'b1, alert);
        set_temp(13'h0600);
        repeat (3) conv_end();
        chk_pin(1'b1, alert);
        set_temp(13'h04af);
        conv_end();
        chk_pin(1'b0, alert);
        rdreg(`TLAC_ADDR_CFG);
        chk_word(cfg_word(2'h1, 2'h0, 2'h0, 1'b0, TLAC_TM_INT), rd);
        chk_pin(1'b1, alert);
        set_temp(13'h0600);
        conv_end();
        chk_pin(1'b0, alert);
        u_host.frame(16'h80ff, 16'h0000, rd);
        chk_pin(1'b1, alert);
        // random limits and samples; result writes are refused
        for (int j = 0; j < 4; j++) begin
            v = 13'($urandom);
            r2 = 2'($urandom);
            wr(`TLAC_ADDR_CFG, cfg_word(2'h3 - r2, r2, 2'($urandom), 1'b0, TLAC_TM_CMP));
            wr({1'b1, j[0]}, {v, 3'($urandom)});
            rdreg({1'b1, j[0]});
            chk_word({v, 1'b1, j[0], 1'b0}, rd);
            set_temp(~v);
            wr(`TLAC_ADDR_TEMP, 16'($urandom));
            conv_end();
            conv_end();
            rdreg(`TLAC_ADDR_TEMP);
            chk_word(res_word(~v, r2), rd);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> tb/tlac_host.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////
// behavioural host controller: serial master, mode 0, 32 ns sck inside frames only
module tlac_host (
    output logic      sck_o,     // serial clock, idle low
    output logic      cs_n_o,    // frame select, active low
    output logic      mosi_o,    // serial data to the device
    input  wire logic miso_i,    // serial data from the device
    input  wire logic miso_oe_i  // device drives miso
);
    // idle bus: deselected, clock standing still
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one frame: 16 command bits then 16 data bits, msb first
    task automatic frame(input logic [15:0] cmd, input logic [15:0] dat, output logic [15:0] rd);
        logic [31:0] w;
        w = {cmd, dat};
        rd = 16'h0000;
        #200 cs_n_o = 1'b0; // deselect gap, then select well ahead of the first edge
        #200;
        for (int i = 31; i >= 0; i--) begin
            mosi_o = w[i];
            #16 sck_o = 1'b1;
            // answer bits are taken on rises 17..32; an undriven line reads unknown
            if (i < 16) begin
                rd[i] = miso_oe_i ? miso_i : 1'bx;
            end
            #16 sck_o = 1'b0;
        end
        #16 cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // released line does not keep its last level
        #250;
    endtask
endmodule
`default_nettype wire
